// >>> src/ldc_cfg_regs.v
/*
  configuration registers of a scan type pwm led driver,
  with the serial command decoder and pwm section timer.
  assumes shift clock, latch and grayscale clock come from
  pins slower than i_clk, with shift clock below 1/4 rate.
*/
`timescale 1ns/1ns
`include "ldc_defs.vh"
module ldc_cfg_regs (
  // clock and reset
  input wire i_clk,
  input wire i_rst_n,
  // serial link pins
  input wire i_serial_data_in,
  input wire i_shift_clock,
  input wire i_latch_enable,
  input wire i_grayscale_clock,
  output reg o_serial_data_out,
  // decoded configuration
  output reg [2:0] o_scan_lines_m1,
  output reg o_depth_14,
  output reg o_grayscale_clock_mult,
  output reg o_ghost_elim,
  output reg o_current_band_select,
  output reg [4:0] o_gain_mantissa,
  output reg o_double_refresh,
  output reg [2:0] o_dim_delay_code,
  output reg [5:0] o_dim_delay_ns,
  // pwm section timing
  output reg [5:0] o_section,
  output reg o_section_start,
  output reg [9:0] o_lsb_count,
  output reg o_soft_reset
);
  reg rst_meta;
  reg rst_n;
  wire sdi_s;
  wire sck_s;
  wire le_s;
  wire gck_s;
  reg sck_d;
  reg le_d;
  reg gck_d;
  reg [15:0] shift;
  reg [3:0] edges;
  reg pre_active;
  reg [15:0] cfg1;
  reg [15:0] cfg2;
  reg [15:0] rd_shift;
  reg [10:0] sect_cnt;
  reg [6:0] sect_idx;
  wire sck_rise;
  wire sck_fall;
  wire le_fall;
  wire gck_rise;
  wire [10:0] sect_len;
  wire [6:0] sect_num;
  wire cmd_wr1;
  wire cmd_rd1;
  wire cmd_wr2;
  wire cmd_rd2;
  wire cmd_srst;
  wire cmd_pre;
  // =====================================================
  // reset release through two flops
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end
  // =====================================================
  // pin synchronisers
  ldc_sync u_sdi (
    .i_clk(i_clk),
    .i_rst_n(rst_n),
    .i_d(i_serial_data_in),
    .o_q(sdi_s)
  );
  ldc_sync u_sck (
    .i_clk(i_clk),
    .i_rst_n(rst_n),
    .i_d(i_shift_clock),
    .o_q(sck_s)
  );
  ldc_sync u_le (
    .i_clk(i_clk),
    .i_rst_n(rst_n),
    .i_d(i_latch_enable),
    .o_q(le_s)
  );
  ldc_sync u_gck (
    .i_clk(i_clk),
    .i_rst_n(rst_n),
    .i_d(i_grayscale_clock),
    .o_q(gck_s)
  );
  // =====================================================
  // edge detection on synchronised pins
  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_d <= 1'b0;
      le_d <= 1'b0;
      gck_d <= 1'b0;
    end else begin
      sck_d <= sck_s;
      le_d <= le_s;
      gck_d <= gck_s;
    end
  end
  assign sck_rise = sck_s & ~sck_d;
  assign sck_fall = ~sck_s & sck_d;
  assign le_fall = ~le_s & le_d;
  assign gck_rise = gck_s & ~gck_d;
  // =====================================================
  // command strobes, one cycle at the end of a latch frame
  assign cmd_wr1 = le_fall && (edges == `LDC_CMD_WR1);
  assign cmd_rd1 = le_fall && (edges == `LDC_CMD_RD1);
  assign cmd_wr2 = le_fall && (edges == `LDC_CMD_WR2);
  assign cmd_rd2 = le_fall && (edges == `LDC_CMD_RD2);
  assign cmd_srst = le_fall && (edges == `LDC_CMD_SRST);
  assign cmd_pre = le_fall && (edges == `LDC_CMD_PRE);
  // =====================================================
  // shift register, command edge counter, config write
  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      shift <= 16'h0000;
      edges <= 4'h0;
      pre_active <= 1'b0;
      cfg1 <= `LDC_CFG1_RST; // R01
      cfg2 <= `LDC_CFG2_RST; // R13
      o_soft_reset <= 1'b0;
    end else begin
      o_soft_reset <= 1'b0;
      // msb first, newest bit into lsb
      if (sck_rise) begin
        shift <= {shift[14:0], sdi_s}; // R18
      end
      if (sck_rise && le_s && edges != 4'hF) begin
        edges <= edges + 4'h1;
      end
      if (le_fall) begin
        edges <= 4'h0;
        // any command other than pre-active ends the pre-active window
        pre_active <= cmd_pre;
        if (cmd_wr1 && pre_active) begin // R17
          // reserved bits stay at default
          cfg1 <= (shift & `LDC_CFG1_WMASK) |
            (`LDC_CFG1_RST & ~`LDC_CFG1_WMASK); // R16 R18
        end
        if (cmd_wr2 && pre_active) begin // R17
          cfg2 <= (shift & `LDC_CFG2_WMASK) |
            (`LDC_CFG2_RST & ~`LDC_CFG2_WMASK); // R16 R18
        end
        // soft reset leaves cfg1 and cfg2 alone
        if (cmd_srst) begin
          o_soft_reset <= 1'b1; // R20
        end
      end
    end
  end
  // =====================================================
  // read back: load on command, shift on falling edge
  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_shift <= 16'h0000;
      o_serial_data_out <= 1'b0;
    end else begin
      if (cmd_rd1) begin
        rd_shift <= cfg1; // R19
        o_serial_data_out <= cfg1[15];
      end else if (cmd_rd2) begin
        rd_shift <= cfg2; // R19
        o_serial_data_out <= cfg2[15];
      end else if (o_soft_reset) begin
        // soft reset empties the readback path
        rd_shift <= 16'h0000; // R20
        o_serial_data_out <= 1'b0;
      end else if (sck_fall && !le_s) begin
        // msb leaves first, output follows shifted data
        rd_shift <= {rd_shift[14:0], shift[15]};
        o_serial_data_out <= rd_shift[14]; // R19
      end
    end
  end
  // =====================================================
  // decoded configuration outputs
  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_scan_lines_m1 <= `LDC_SCAN_RST;
      o_depth_14 <= 1'b0;
      o_grayscale_clock_mult <= 1'b0;
      o_ghost_elim <= 1'b0;
      o_current_band_select <= `LDC_BAND_RST;
      o_gain_mantissa <= `LDC_MANT_RST;
      o_double_refresh <= 1'b0;
      o_dim_delay_code <= 3'h0;
      o_dim_delay_ns <= 6'h00;
    end else begin
      o_scan_lines_m1 <= cfg1[`LDC_SCAN_HI:`LDC_SCAN_LO]; // R02
      o_depth_14 <= cfg1[`LDC_DEPTH_BIT]; // R03
      o_grayscale_clock_mult <= cfg1[`LDC_MULT_BIT]; // R08
      o_ghost_elim <= cfg1[`LDC_GHOST_BIT]; // R15
      // band exponent plus mantissa D; host applies formula
      o_current_band_select <= cfg1[`LDC_BAND_BIT]; // R09 R10 R12
      o_gain_mantissa <= cfg1[`LDC_MANT_HI:0]; // R11
      o_double_refresh <= cfg2[`LDC_DBL_BIT]; // R15
      o_dim_delay_code <= cfg2[`LDC_DIM_HI:`LDC_DIM_LO];
      o_dim_delay_ns <= {3'h0, cfg2[`LDC_DIM_HI:`LDC_DIM_LO]} *
        `LDC_DIM_STEP_NS; // R14
    end
  end
  // =====================================================
  // pwm section timer on grayscale clock edges
  assign sect_len = cfg1[`LDC_DEPTH_BIT] ? `LDC_SECT14
    : `LDC_SECT16; // R04 R05
  assign sect_num = cfg1[`LDC_DEPTH_BIT] ? `LDC_NSEC14
    : `LDC_NSEC16; // R04 R05
  // lsb count is the in-section part, section the msb part counted in order
  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      sect_cnt <= 11'h000;
      sect_idx <= 7'h00;
      o_section <= 6'h00;
      o_section_start <= 1'b0;
      o_lsb_count <= 10'h000;
    end else begin
      o_section_start <= 1'b0;
      if (o_soft_reset) begin
        sect_cnt <= 11'h000;
        sect_idx <= 7'h00;
      end else if (gck_rise) begin
        if (sect_cnt + 11'h001 >= sect_len) begin
          sect_cnt <= 11'h000;
          o_section_start <= 1'b1;
          if (sect_idx + 7'h01 >= sect_num) begin
            sect_idx <= 7'h00;
          end else begin
            sect_idx <= sect_idx + 7'h01; // R07
          end
        end else begin
          sect_cnt <= sect_cnt + 11'h001;
        end
      end
      o_section <= sect_idx[5:0];
      o_lsb_count <= sect_cnt[9:0]; // R07
    end
  end
endmodule

// >>> common/ldc_defs.vh
// What this block does
// [R01] config one 16 bits, resets to 032B
// [R02] bits 10:8 give scan lines minus one
// [R03] bit 7 picks 16 or 14 bit
// [R04] 16-bit: 64 sections of 1024 clocks
// [R05] 14-bit: 32 sections of 512 clocks
// [R06] controller pads 14-bit words with zeros
// [R07] msb part scrambled, lsb part kept; code counts sections in order, unscrambled
// [R08] bit 6 enables grayscale clock multiplier
// [R09] bits 5:0 are 64-step current gain
// [R10] bit 5 selects low or high band
// [R11] gain is band exponent, 5-bit mantissa
// [R12] mantissa relates to gain by band formula
// [R13] config two 16 bits, resets to 1010
// [R14] bits 3:1 give 5 ns delay steps
// [R15] ghost bit 15, double refresh bit 10
// [R16] reserved bits ignored, read as default
// [R17] write needs prior pre-active command
// [R18] write loads last 16 bits, msb first
// [R19] read shifts register out msb first
// [R20] soft reset keeps configuration registers
/*
  constants of the led driver configuration block.
  assumes inclusion by bare name from the design files.
*/
`ifndef LDC_DEFS_VH
`define LDC_DEFS_VH
// =====================================================
// reset values
`define LDC_CFG1_RST 16'h032B
`define LDC_CFG2_RST 16'h1010
// decoded field defaults seen while reset is held
`define LDC_SCAN_RST 3'h3
`define LDC_BAND_RST 1'h1
`define LDC_MANT_RST 5'h0B
// writable bit masks; other bits are reserved
`define LDC_CFG1_WMASK 16'h87FF
`define LDC_CFG2_WMASK 16'h040E
// =====================================================
// field positions
`define LDC_GHOST_BIT 15
`define LDC_SCAN_HI 10
`define LDC_SCAN_LO 8
`define LDC_DEPTH_BIT 7
`define LDC_MULT_BIT 6
`define LDC_BAND_BIT 5
`define LDC_MANT_HI 4
`define LDC_DBL_BIT 10
`define LDC_DIM_HI 3
`define LDC_DIM_LO 1
// =====================================================
// command codes: edges of shift clock while latch high
`define LDC_CMD_WR1 4'h4
`define LDC_CMD_RD1 4'h5
`define LDC_CMD_WR2 4'h8
`define LDC_CMD_RD2 4'h9
`define LDC_CMD_SRST 4'hA
`define LDC_CMD_PRE 4'hE
// =====================================================
// timing
`define LDC_SECT16 11'h400
`define LDC_SECT14 11'h200
`define LDC_NSEC16 7'h40
`define LDC_NSEC14 7'h20
`define LDC_DIM_STEP_NS 6'h05
`define LDC_CLK_NS 20
`endif

// >>> src/ldc_sync.v
/*
  two flip-flop synchroniser for one level.
  assumes a free running clock and async active-low reset.
*/
`timescale 1ns/1ns
module ldc_sync (
  // clock and reset
  input wire i_clk,
  input wire i_rst_n,
  // level in and out
  input wire i_d,
  output reg o_q
);
  reg meta;
  // =====================================================
  // double register
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta <= 1'b0;
      o_q <= 1'b0;
    end else begin
      meta <= i_d;
      o_q <= meta;
    end
  end
endmodule

// >>> testbench/ldc_assertions.sv
/*
  port checks of the led driver configuration block.
  assumes a bind onto ldc_cfg_regs and one clock domain.
*/
`timescale 1ns/1ns
module ldc_assertions (
  // clock, reset and pins
  input logic i_clk, i_rst_n, i_serial_data_in, i_shift_clock,
  input logic i_latch_enable, i_grayscale_clock, o_serial_data_out,
  // decoded configuration and timing
  input logic [2:0] o_scan_lines_m1, o_dim_delay_code,
  input logic o_depth_14, o_grayscale_clock_mult, o_ghost_elim, o_double_refresh,
  input logic o_current_band_select, o_soft_reset, o_section_start,
  input logic [4:0] o_gain_mantissa,
  input logic [5:0] o_dim_delay_ns, o_section,
  input logic [9:0] o_lsb_count
);
  // ==========================================
  // cycles since the latch pin last fell
  logic le_q;
  logic [3:0] since_fall;
  wire [15:0] cfg_all = {o_ghost_elim, o_scan_lines_m1, o_depth_14,
    o_grayscale_clock_mult, o_current_band_select, o_gain_mantissa,
    o_double_refresh, o_dim_delay_code};
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      le_q <= 1'b0;
      since_fall <= 4'hF;
    end else begin
      le_q <= i_latch_enable;
      if (le_q && !i_latch_enable)
        since_fall <= 4'h0;
      else if (since_fall != 4'hF)
        since_fall <= since_fall + 4'h1;
    end
  end
  // ==========================================
  // properties
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_pulse_drop;
    o_soft_reset ##1 !o_soft_reset;
  endsequence
  a_reset_dflt: assert property (
    $rose(i_rst_n) |-> cfg_all == 16'h32B0 && o_dim_delay_ns == 6'h00)
    else $error("config outputs not at defaults after reset");
  a_cfg_settle: assert property (
    $changed(cfg_all) |-> since_fall <= 4'h8)
    else $error("config changed without a command frame");
  a_dim_scale: assert property (
    $stable(o_dim_delay_code) |->
      o_dim_delay_ns == {3'h0, o_dim_delay_code} * 6'h05)
    else $error("dim delay ns not five times the code");
  a_srst_pulse: assert property (
    o_soft_reset |-> s_pulse_drop)
    else $error("soft reset pulse longer than one cycle");
  a_srst_cause: assert property (
    o_soft_reset |-> since_fall <= 4'h8)
    else $error("soft reset without a command frame");
  a_srst_keeps: assert property (
    o_soft_reset |=> $stable(cfg_all) [*3])
    else $error("soft reset disturbed config");
  a_lsb_step: assert property (
    $changed(o_lsb_count) |->
      o_lsb_count == $past(o_lsb_count) + 10'h1 || o_lsb_count == 10'h0)
    else $error("lsb count skipped");
  a_sect_step: assert property (
    $changed(o_section) |->
      o_section == $past(o_section) + 6'h1 || o_section == 6'h00)
    else $error("section index skipped");
endmodule

// >>> testbench/ldc_ctrl_model.sv
/*
  display controller model: shift clock, latch and data pins.
  assumes i_clk is the block clock; calls start at its fall.
*/
`timescale 1ns/1ns
module ldc_ctrl_model (
  input logic i_clk, i_sdo,
  output logic o_sdi = 1'b0, o_sclk = 1'b0, o_le = 1'b0
);
  logic last_sdo;
  // one 160 ns shift clock period, readback taken before the fall
  task automatic pulse(input logic d);
    o_sdi = d;
    repeat (4) @(negedge i_clk);
    o_sclk = 1'b1;
    repeat (4) @(negedge i_clk);
    last_sdo = i_sdo;
    o_sclk = 1'b0;
  endtask
  // bits msb first, the last nhi of them with latch high
  task automatic frame(input logic [15:0] w, input int nlo, input int nhi);
    for (int i = nlo + nhi - 1; i >= 0; i--) begin
      if (i == nhi - 1)
        o_le = 1'b1;
      pulse(w[i]);
    end
    repeat (4) @(negedge i_clk);
    o_le = 1'b0;
    o_sdi = ~o_sdi; // released line shows inverse
    repeat (8) @(negedge i_clk);
  endtask
  // pre-active, then the word with the write command in its tail
  task automatic write(input int c, input logic [15:0] w);
    frame(16'h0000, 0, 14);
    frame(w, 16 - c, c);
  endtask
  // one 14-bit grayscale word, two zero lsbs, data latch command
  task automatic pixel(input logic [13:0] g);
    frame({g, 2'h0}, 15, 1);
  endtask
  // sixteen readback bits, msb first
  task automatic read(output logic [15:0] q);
    for (int i = 15; i >= 0; i--) begin
      pulse(1'b0);
      q[i] = last_sdo;
    end
  endtask
endmodule

// >>> testbench/ldc_cfg_regs_tb.sv
/*
  self-checking bench of the led driver configuration block.
  assumes design, checker and controller model compiled first.
*/
`timescale 1ns/1ns
module ldc_cfg_regs_tb;
  // ==========================================
  // pins, clock and counters
  logic i_clk = 1'b0, i_rst_n = 1'b0, i_grayscale_clock = 1'b0;
  wire i_serial_data_in, i_shift_clock, i_latch_enable, o_serial_data_out;
  wire [2:0] o_scan_lines_m1, o_dim_delay_code;
  wire o_depth_14, o_grayscale_clock_mult, o_ghost_elim, o_double_refresh;
  wire o_current_band_select, o_soft_reset, o_section_start;
  wire [4:0] o_gain_mantissa;
  wire [5:0] o_dim_delay_ns, o_section;
  wire [9:0] o_lsb_count;
  int miscompares = 0, compares = 0;
  logic [15:0] rd;
  always #10 i_clk = ~i_clk;
  ldc_cfg_regs DUT (.*);
  ldc_ctrl_model m (.i_clk(i_clk), .i_sdo(o_serial_data_out),
    .o_sdi(i_serial_data_in), .o_sclk(i_shift_clock), .o_le(i_latch_enable));
  // config pins packed as register words, reserved at default
  function automatic logic [15:0] pins1();
    return {o_ghost_elim, 4'h0, o_scan_lines_m1, o_depth_14, o_grayscale_clock_mult,
      o_current_band_select, o_gain_mantissa};
  endfunction
  function automatic logic [15:0] pins2();
    return {5'h02, o_double_refresh, 6'h01, o_dim_delay_code, 1'b0};
  endfunction
  // ==========================================
  // compare and verdict
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wrap_up;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ==========================================
  // scenarios
  task automatic t_defaults;
    chk("cfg1_pins", 16'h032B, pins1());
    chk("cfg2_pins", 16'h1010, pins2());
    m.frame(16'h0000, 0, 5);
    m.read(rd);
    chk("cfg1_read", 16'h032B, rd);
    m.frame(16'h0000, 0, 9);
    m.read(rd);
    chk("cfg2_read", 16'h1010, rd);
  endtask
  // gain 6'h30: high band, d = (65*1.246-33)/3 = 16
  task automatic t_write1;
    m.write(4, 16'hFFF0);
    chk("cfg1_pins", 16'h87F0, pins1());
    m.frame(16'h0000, 0, 5);
    m.read(rd);
    chk("cfg1_read", 16'h87F0, rd);
  endtask
  // pre-active spoilt by a read in between
  task automatic t_nopre;
    m.frame(16'h0000, 0, 14);
    m.frame(16'h0000, 0, 9);
    m.frame(16'h0000, 12, 4);
    m.pixel(14'h1234);
    chk("cfg1_pins", 16'h87F0, pins1());
  endtask
  task automatic t_dim;
    logic [2:0] c;
    for (int i = 0; i < 8; i++) begin
      c = i[2:0];
      m.write(8, {5'h1F, c[0], 6'h3F, c, 1'b1});
      chk("cfg2_pins", {5'h02, c[0], 6'h01, c, 1'b0}, pins2());
      chk("dim_ns", 16'(i * 5), {10'h0, o_dim_delay_ns});
    end
    m.frame(16'h0000, 0, 9);
    m.read(rd);
    chk("cfg2_read", 16'h141E, rd);
  endtask
  task automatic t_srst(input logic [15:0] e1);
    logic seen;
    seen = 1'b0;
    fork
      m.frame(16'h0000, 0, 10);
      repeat (120) @(negedge i_clk) if (o_soft_reset === 1'b1) seen = 1'b1;
    join
    chk("soft_reset", 16'h0001, {15'h0, seen});
    if (seen !== 1'b1)
      wrap_up();
    chk("cfg1_kept", e1, pins1());
  endtask
  // n grayscale clock rises after a soft reset
  task automatic t_sect(input int n, input int len);
    int starts;
    starts = 0;
    for (int k = 0; k < n * 4 + 8; k++) begin
      i_grayscale_clock = (k < n * 4) && (k % 4 < 2);
      @(negedge i_clk);
      if (o_section_start === 1'b1)
        starts++;
    end
    chk("section", 16'(n / len), {10'h0, o_section});
    chk("lsb_count", 16'(n % len), {6'h0, o_lsb_count});
    chk("sect_starts", 16'(n / len), 16'(starts));
  endtask
  initial begin
    repeat (4) @(negedge i_clk);
    i_rst_n = 1'b1;
    repeat (6) @(negedge i_clk);
    t_defaults;
    t_srst(16'h032B);
    t_sect(1027, 1024);
    t_write1;
    t_nopre;
    t_dim;
    t_srst(16'h87F0);
    t_sect(515, 512);
    wrap_up;
  end
endmodule
bind ldc_cfg_regs ldc_assertions u_chk (.*);
